// *** pkg/psdio_pkg.sv ***
/*
  Shared constants and types for the pipelined SRAM data and control core.
  Assumes a single rising-edge clock and a synchronous external controller.
*/
package psdio_pkg;
  localparam int ADDR_W     = 8;                 // Word address width of the array
  localparam int LANES      = 4;                 // Byte lanes, one parity bit each
  localparam int BYTE_W     = 8;                 // Bits per data byte lane
  localparam int DATA_W     = LANES * BYTE_W;    // Data bus width
  localparam int WORDS      = 1 << ADDR_W;       // Array depth
  localparam int WBUF_DEPTH = 16;                // Write buffer depth
  localparam int BURST_W    = 2;                 // Burst counter width
  localparam int CLK_PERIOD_NS = 4;              // Clock period in ns

  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;  // Burst count at load
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;  // Burst count step
  localparam logic               MODE_INTERLEAVED = 1'h1; // Strap level for interleaved

  // One-hot access kind carried down the pipeline
  typedef enum logic [2:0] {
    CMD_IDLE  = 3'b001,
    CMD_READ  = 3'b010,
    CMD_WRITE = 3'b100
  } psdio_cmd_type;

  // Data word with its parity lanes
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  parity;
  } psdio_lane_type;

  // One pipelined access stage
  typedef struct packed {
    psdio_cmd_type     cmd;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  bsel_n;
  } psdio_stage_type;

  // Write buffer entry
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  bsel_n;
    psdio_lane_type    word;
  } psdio_wentry_type;

  localparam int WENTRY_W = $bits(psdio_wentry_type);  // Buffer word width
endpackage

// *** core/psdio_core.sv ***
/*
  Pipelined burst SRAM core: array, input registers, burst counter,
  output register and output-enable masking, plus its write buffer.
  Assumes the controller drives all inputs synchronous to mclk_i.
*/
// Functional notes
// - Drive data and parity when enable low, unmasked.
// - Enable high tristates lanes, lanes become inputs.
// - Mask drive on write data, re-select, deselect.
// - Act on edges with qualifier low; enable high drops drive on any edge with clk_en_i high.
// - Qualifier high stretches cycle, keeps selection.
// - Capture input lanes on rising edge.
// - Read data appears one cycle after address.
// - Parity lanes follow data and byte selects.
// - Strap high interleaved, low linear burst order.
// - Unset strap defaults to interleaved order.
// - Select needs cs1 low, cs2 high, cs3 low.
// - Byte selects with write strobe gate lanes.
// - Burst walks two low bits, wraps after four.
`timescale 1ns/1ps

module psdio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];        // Storage
  logic [PTR_W-1:0] wr_ptr;             // Fill pointer
  logic [PTR_W-1:0] rd_ptr;             // Drain pointer
  logic [PTR_W:0]   count;              // Words held
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0]   next_count;
  logic             push;               // Word accepted
  logic             pop;                // Word removed

  assign in_ready_o  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Pointer and count update
  always_comb begin
    push        = en_i & in_valid_i & in_ready_o;
    pop         = en_i & out_valid_o & out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  // Pointer registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

module psdio_core
  import psdio_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              clock_qualifier_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              chip_select_1_n_i,
  input  wire logic              chip_select_2_i,
  input  wire logic              chip_select_3_n_i,
  input  wire logic              write_en_n_i,
  input  wire logic              advance_or_load_i,
  input  wire logic [LANES-1:0]  byte_lane_write_sel_n_i,
  input  wire logic              out_en_n_i,
  input  wire logic              burst_mode_i,
  input  wire logic [DATA_W-1:0] data_in_i,
  input  wire logic [LANES-1:0]  parity_lines_in_i,
  output logic      [DATA_W-1:0] data_out_o,
  output logic      [LANES-1:0]  parity_lines_out_o,
  output logic                   data_oe_o,
  output logic                   wbuf_ready_o
);
  // Interleaved or linear burst address from base and count
  function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] base,
                                                      input logic [BURST_W-1:0] cnt,
                                                      input logic               ilv);
    burst_addr = ilv ? (base ^ cnt) : (base + cnt);
  endfunction

  psdio_lane_type    mem [WORDS];       // Array
  logic              ce;                // Qualified clock edge
  psdio_stage_type   stage1;            // Access taken at last edge
  psdio_stage_type   stage2;            // Write waiting for its data
  psdio_stage_type   next_stage1;
  psdio_stage_type   next_stage2;
  logic [ADDR_W-1:0] burst_base;        // Loaded address
  logic [BURST_W-1:0] burst_cnt;        // Burst position
  logic              burst_wr;          // Access kind latched at load
  logic              burst_act;         // Burst may advance
  logic [ADDR_W-1:0] next_burst_base;
  logic [BURST_W-1:0] next_burst_cnt;
  logic              next_burst_wr;
  logic              next_burst_act;
  logic              mode_ilv;          // Captured burst order
  logic              mode_taken;        // Strap already caught
  logic              next_mode_ilv;
  logic              next_mode_taken;
  psdio_lane_type    out_reg;           // Output register
  psdio_lane_type    next_out_reg;
  logic              next_oe;
  logic              next_wbuf_ready;
  logic              selected;          // Chip select decode
  logic [ADDR_W-1:0] cur_addr;          // Address of the advancing burst
  psdio_wentry_type  wb_in;             // Captured write word
  psdio_wentry_type  wb_out;            // Word leaving the buffer
  logic              wb_in_valid;
  logic              wb_in_ready;
  logic              wb_out_valid;
  logic              wb_drain;          // Buffer may retire a word

  assign ce = clk_en_i & ~clock_qualifier_n_i;
  assign data_out_o         = out_reg.data;
  assign parity_lines_out_o = out_reg.parity;

  // Strap capture after reset release, interleaved until then
  always_comb begin
    next_mode_ilv   = mode_ilv;
    next_mode_taken = mode_taken;
    if (ce && !mode_taken) begin
      next_mode_ilv   = burst_mode_i;
      next_mode_taken = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ilv   <= MODE_INTERLEAVED;
      mode_taken <= 1'b0;
    end else begin
      mode_ilv   <= next_mode_ilv;
      mode_taken <= next_mode_taken;
    end
  end

  // Command decode, burst counter and pipeline stages
  always_comb begin
    selected        = ~chip_select_1_n_i & chip_select_2_i & ~chip_select_3_n_i;
    cur_addr        = {burst_base[ADDR_W-1:BURST_W],
                       burst_addr(burst_base[BURST_W-1:0], burst_cnt + BURST_ONE, mode_ilv)};
    next_stage1     = stage1;
    next_stage2     = stage2;
    next_burst_base = burst_base;
    next_burst_cnt  = burst_cnt;
    next_burst_wr   = burst_wr;
    next_burst_act  = burst_act;
    if (ce) begin
      next_stage2 = stage1;
      next_stage1.bsel_n = byte_lane_write_sel_n_i;
      if (!advance_or_load_i) begin
        if (selected) begin
          next_stage1.cmd  = write_en_n_i ? CMD_READ : CMD_WRITE;
          next_stage1.addr = addr_i;
          next_burst_base  = addr_i;
          next_burst_cnt   = BURST_ZERO;
          next_burst_wr    = ~write_en_n_i;
          next_burst_act   = 1'b1;
        end else begin
          next_stage1.cmd = CMD_IDLE;
          next_burst_act  = 1'b0;
        end
      end else if (burst_act) begin
        next_stage1.cmd  = burst_wr ? CMD_WRITE : CMD_READ;
        next_stage1.addr = cur_addr;
        next_burst_cnt   = burst_cnt + BURST_ONE;
      end else begin
        next_stage1.cmd = CMD_IDLE;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1     <= '{cmd: CMD_IDLE, addr: '0, bsel_n: '1};
      stage2     <= '{cmd: CMD_IDLE, addr: '0, bsel_n: '1};
      burst_base <= '0;
      burst_cnt  <= BURST_ZERO;
      burst_wr   <= 1'b0;
      burst_act  <= 1'b0;
    end else begin
      stage1     <= next_stage1;
      stage2     <= next_stage2;
      burst_base <= next_burst_base;
      burst_cnt  <= next_burst_cnt;
      burst_wr   <= next_burst_wr;
      burst_act  <= next_burst_act;
    end
  end

  // Output register and drive enable
  always_comb begin
    next_out_reg    = out_reg;
    next_oe         = data_oe_o;
    next_wbuf_ready = clk_en_i ? wb_in_ready : wbuf_ready_o;
    if (ce) begin
      case (stage1.cmd)
        CMD_READ: begin
          next_out_reg = mem[stage1.addr];
          next_oe      = ~out_en_n_i;
        end
        CMD_WRITE: begin
          next_oe = 1'b0;
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end else if (clk_en_i && out_en_n_i) begin
      next_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg      <= '0;
      data_oe_o    <= 1'b0;
      wbuf_ready_o <= 1'b1;
    end else begin
      out_reg      <= next_out_reg;
      data_oe_o    <= next_oe;
      wbuf_ready_o <= next_wbuf_ready;
    end
  end

  // Write data capture into the buffer
  always_comb begin
    wb_in_valid      = ce & (stage2.cmd == CMD_WRITE);
    wb_in.addr       = stage2.addr;
    wb_in.bsel_n     = stage2.bsel_n;
    wb_in.word.data   = data_in_i;
    wb_in.word.parity = parity_lines_in_i;
    wb_drain         = (stage1.cmd != CMD_READ) | ~wb_in_ready;
  end

  psdio_fifo #(
    .WIDTH (WENTRY_W),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .en_i        (ce),
    .in_valid_i  (wb_in_valid),
    .in_ready_o  (wb_in_ready),
    .in_data_i   (wb_in),
    .out_valid_o (wb_out_valid),
    .out_ready_i (wb_drain),
    .out_data_o  (wb_out)
  );

  // Retire buffered writes per byte lane
  always_ff @(posedge mclk_i) begin
    if (ce && wb_out_valid && wb_drain) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wb_out.bsel_n[i]) begin
          mem[wb_out.addr].data[i*BYTE_W +: BYTE_W] <=
            wb_out.word.data[i*BYTE_W +: BYTE_W];
          mem[wb_out.addr].parity[i] <= wb_out.word.parity[i];
        end
      end
    end
  end
endmodule

// *** test/psdio_ctrl_model.sv ***
/*
  Memory controller model: drives access pins and the write data lanes.
  Assumes one op call per qualified edge; the bench owns the qualifier.
*/
`timescale 1ns/1ps
module psdio_ctrl_model
  import psdio_pkg::*;
(
  input  wire logic               mclk_i,
  output logic      [2:0]         cs_o,
  output logic                    we_n_o,
  output logic                    adv_o,
  output logic      [ADDR_W-1:0]  addr_o,
  output logic      [LANES-1:0]   bsel_n_o,
  output psdio_lane_type          lane_o
);
  psdio_lane_type pipe [2];  // Write words awaiting data phase
  logic           pv   [2];  // Pipe slot holds a write

  // Idle bus, nothing queued
  initial begin
    cs_o = 3'h3;
    we_n_o = 1'h1;
    adv_o = 1'h0;
    addr_o = '0;
    bsel_n_o = '1;
    lane_o = '0;
    pv = '{1'h0, 1'h0};
  end

  // One access; cs is {cs3_n, cs2, cs1_n}
  task automatic op(input logic [2:0] cs, input logic we_n, adv,
                    input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bs,
                    input psdio_lane_type wd);
    @(posedge mclk_i);
    #1;
    cs_o = cs;
    we_n_o = we_n;
    adv_o = adv;
    addr_o = a;
    bsel_n_o = bs;
    lane_o = pv[1] ? pipe[1] : ~lane_o;  // Data two edges on; released lanes flip
    pipe[1] = pipe[0];
    pv[1] = pv[0];
    pipe[0] = wd;
    pv[0] = !we_n;
  endtask
endmodule

// *** test/psdio_core_asserts.sv ***
/*
  Checker for output-enable masking and clock qualification of psdio_core.
  Assumes it is bound to psdio_core and sees only its ports.
*/
`timescale 1ns/1ps
module psdio_core_asserts
  import psdio_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              clock_qualifier_n_i,
  input  wire logic              chip_select_1_n_i,
  input  wire logic              chip_select_2_i,
  input  wire logic              chip_select_3_n_i,
  input  wire logic              write_en_n_i,
  input  wire logic              advance_or_load_i,
  input  wire logic              out_en_n_i,
  input  wire logic [DATA_W-1:0] data_out_o,
  input  wire logic [LANES-1:0]  parity_lines_out_o,
  input  wire logic              data_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic q;    // Qualified edge
  logic sel;  // All selects active
  logic ld;   // Load cycle
  assign q = clk_en_i & ~clock_qualifier_n_i;
  assign sel = ~chip_select_1_n_i & chip_select_2_i & ~chip_select_3_n_i;
  assign ld = ~advance_or_load_i;

  a_read_drive: assert property
    (q && ld && sel && write_en_n_i ##1 q && !out_en_n_i |=> data_oe_o)
    else $error("read not driven");
  a_oe_high_off: assert property (q && out_en_n_i |=> !data_oe_o)
    else $error("oe high still driving");
  a_write_mask: assert property (q && ld && sel && !write_en_n_i ##1 q |=> !data_oe_o)
    else $error("driven in write data phase");
  a_dsel_mask: assert property (q && ld && !sel ##1 q |=> !data_oe_o)
    else $error("driven after deselect");
  a_dsel_adv_idle: assert property
    (q && ld && !sel ##1 q && advance_or_load_i ##1 q |=> !data_oe_o)
    else $error("advance after deselect drove");
  a_burst_wmask: assert property
    (q && ld && sel && !write_en_n_i ##1 q && advance_or_load_i ##1 q |=> !data_oe_o)
    else $error("write burst drove");
  a_mask_hold: assert property (!q |=> $stable({data_out_o, parity_lines_out_o}))
    else $error("output moved on masked edge");
  a_mask_no_rise: assert property (!q |=> !$rose(data_oe_o))
    else $error("oe rose on masked edge");

  c_read: cover property (q && ld && sel && write_en_n_i ##2 data_oe_o);
  c_write: cover property (q && ld && sel && !write_en_n_i);
  c_stall: cover property (clock_qualifier_n_i && data_oe_o);
endmodule

bind psdio_core psdio_core_asserts u_chk (
  .mclk_i, .rst_i, .clk_en_i, .clock_qualifier_n_i, .chip_select_1_n_i,
  .chip_select_2_i, .chip_select_3_n_i, .write_en_n_i, .advance_or_load_i,
  .out_en_n_i, .data_out_o, .parity_lines_out_o, .data_oe_o
);

// *** test/psdio_core_test.sv ***
/*
  Self-checking bench for psdio_core driven by a controller model.
  Assumes psdio_pkg, the model and the checker are compiled first.
*/
`timescale 1ns/1ps
module psdio_core_test;
  import psdio_pkg::*;
  logic                mclk = 1'h0;    // Clock
  logic                rst = 1'h1;     // Reset
  logic                clk_en = 1'h1;  // Global run
  logic                qual_n = 1'h0;  // Clock qualifier
  logic                oe_n = 1'h0;    // Output enable
  logic                mode = 1'h1;    // Burst strap
  logic [2:0]          cs;
  logic                we_n;
  logic                adv;
  logic [ADDR_W-1:0]   addr;
  logic [LANES-1:0]    bs;
  psdio_lane_type      lane;
  logic [DATA_W-1:0]   dout;
  logic [LANES-1:0]    pout;
  logic                oe;
  logic                wrdy;           // Write buffer has room
  psdio_lane_type      mem [WORDS];    // Expected array
  int                  n_mismatch = 0;
  int                  check_count = 0;

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  psdio_ctrl_model u_ctl (.mclk_i(mclk), .cs_o(cs), .we_n_o(we_n), .adv_o(adv),
    .addr_o(addr), .bsel_n_o(bs), .lane_o(lane));
  psdio_core dut (.mclk_i(mclk), .rst_i(rst), .clk_en_i(clk_en),
    .clock_qualifier_n_i(qual_n), .addr_i(addr), .chip_select_1_n_i(cs[0]),
    .chip_select_2_i(cs[1]), .chip_select_3_n_i(cs[2]), .write_en_n_i(we_n),
    .advance_or_load_i(adv), .byte_lane_write_sel_n_i(bs), .out_en_n_i(oe_n),
    .burst_mode_i(mode), .data_in_i(lane.data), .parity_lines_in_i(lane.parity),
    .data_out_o(dout), .parity_lines_out_o(pout), .data_oe_o(oe), .wbuf_ready_o(wrdy));

  task automatic chk(input string nm, input logic [DATA_W+LANES-1:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Burst address for beat i
  function automatic logic [ADDR_W-1:0] ba(input logic [ADDR_W-1:0] a, input int i,
                                           input logic m);
    ba = a;
    ba[1:0] = m ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
  endfunction

  // Write and track lanes that are enabled
  task automatic wr(input logic v, input logic [ADDR_W-1:0] a, ea,
                    input logic [LANES-1:0] b, input psdio_lane_type d);
    u_ctl.op(3'h2, 1'h0, v, a, b, d);
    for (int i = 0; i < LANES; i++) begin
      if (!b[i]) begin
        mem[ea].data[i*BYTE_W+:BYTE_W] = d.data[i*BYTE_W+:BYTE_W];
        mem[ea].parity[i] = d.parity[i];
      end
    end
  endtask

  task automatic rd(input logic v, input logic [ADDR_W-1:0] a);
    u_ctl.op(3'h2, 1'h1, v, a, 4'hf, '0);
  endtask

  task automatic id();
    u_ctl.op(3'h3, 1'h1, 1'h0, '0, 4'hf, '0);
  endtask

  task automatic reset(input logic m);
    rst = 1'h1;
    mode = m;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'h0;
    chk("oe_rst", oe, 1'h0);
  endtask

  // Write burst, single reads, then read burst
  task automatic t_burst(input logic m);
    reset(m);
    for (int i = 0; i < 4; i++) begin
      wr(i != 0, 8'h11, ba(8'h11, i, m), 4'h0, {32'h5a000000 + 32'(i), 4'(i)});
    end
    repeat (6) id();
    for (int j = 0; j < 4; j++) begin
      rd(1'h0, 8'h10 + 8'(j));
      id();
      id();
      chk("single", {dout, pout}, mem[8'h10 + 8'(j)]);
    end
    rd(1'h0, 8'h13);
    rd(1'h1, 8'h13);
    for (int i = 0; i < 4; i++) begin
      if (i < 2) rd(1'h1, 8'h13);
      else id();
      chk("beat", {dout, pout}, mem[ba(8'h13, i, m)]);
      chk("oe_rd", oe, 1'h1);
    end
  endtask

  // Partial byte write, advance while deselected
  task automatic t_lanes();
    wr(1'h0, 8'h40, 8'h40, 4'h0, psdio_lane_type'(36'h123456789));
    wr(1'h0, 8'h40, 8'h40, 4'ha, psdio_lane_type'(36'hfedcba987));
    repeat (4) id();
    chk("wbuf", wrdy, 1'h1);
    rd(1'h1, 8'h00);
    rd(1'h0, 8'h40);
    id();
    chk("oe_adv", oe, 1'h0);
    id();
    chk("lane", {dout, pout}, mem[8'h40]);
  endtask

  // Masked edges hold output; oe can still fall
  task automatic t_stall();
    rd(1'h0, 8'h40);
    rd(1'h0, 8'h13);
    id();
    qual_n = 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    chk("hold", {dout, pout}, mem[8'h40]);
    chk("oe_hold", oe, 1'h1);
    oe_n = 1'h1;
    @(posedge mclk);
    #1;
    chk("oe_off", oe, 1'h0);
    clk_en = 1'h0;
    qual_n = 1'h0;
    oe_n = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk("frozen", oe, 1'h0);
    clk_en = 1'h1;
    oe_n = 1'h1;
    rd(1'h0, 8'h40);
    id();
    id();
    chk("oe_n_high", oe, 1'h0);
    chk("undriven", {dout, pout}, mem[8'h40]);
    oe_n = 1'h0;
  endtask

  // Each single missing select deselects
  task automatic t_sel();
    logic [2:0] cd [3];
    cd = '{3'h3, 3'h0, 3'h6};
    for (int i = 0; i < 3; i++) begin
      u_ctl.op(cd[i], 1'h1, 1'h0, 8'h40, 4'hf, '0);
      id();
      id();
      chk("oe_sel", oe, 1'h0);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_burst(1'h1);
    t_burst(1'h0);
    t_lanes();
    t_stall();
    t_sel();
    close_out();
  end

  // Watchdog
  initial begin
    #(CLK_PERIOD_NS * 2000);
    n_mismatch++;
    close_out();
  end
endmodule
